// ---- src/twsm_map.vh ----
// constants for the two-wire single-master controller
`ifndef TWSM_MAP_VH
`define TWSM_MAP_VH
// ==================================================
// timing
`define TWSM_PRESCALE 16
`define TWSM_DIV_MUL 16
`define TWSM_DIV_ADD 4
`define TWSM_PHASES 4
`define TWSM_PCLK_MAX_MHZ 33
`define TWSM_DIV_W 4
`define TWSM_DIV_RST 4'h4
// ==================================================
// data register layout
`define TWSM_DATA_W 24
`define TWSM_RW_BIT 16
`define TWSM_BYTE_W 8
`endif

// ---- src/twsm_tick.v ----
// quarter-bit tick generator: fixed prescaler then programmable divider
`timescale 1ns/100ps
`default_nettype none
`include "twsm_map.vh"
module twsm_tick #(
   parameter DIV_W = `TWSM_DIV_W
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire run,
   input wire [DIV_W-1:0] bit_rate_divider,
   output wire tick
);
   // ==================================================
   // prescaler and divider
   reg [3:0] pre_q;
   reg [DIV_W-1:0] unit_q;
   wire pre_tc;
   // [RQ3] fixed divide by 16
   assign pre_tc = (pre_q == 4'hF);
   // [RQ5] phase is div prescaled units plus 4 clocks: 16*div+4 clocks
   assign tick = run && (unit_q == bit_rate_divider) && (pre_q == 4'h3);
   always @(posedge clk) begin
      if (rst) begin
         pre_q <= 4'h0;
         unit_q <= {DIV_W{1'b0}};
      end else if (ce) begin
         // restart whenever the phase may not run, so a wait costs a phase
         if (!run || tick) begin
            pre_q <= 4'h0;
            unit_q <= {DIV_W{1'b0}};
         end else begin
            pre_q <= pre_q + 4'h1;
            // [RQ4] divider counts prescaled units
            if (pre_tc) begin
               unit_q <= unit_q + {{(DIV_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/twsm_shift.v ----
// 24-bit data register: load, shift left, receive into low byte
`timescale 1ns/100ps
`default_nettype none
`include "twsm_map.vh"
module twsm_shift #(
   parameter W = `TWSM_DATA_W
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire load,
   input wire [W-1:0] load_data,
   input wire shift,
   input wire shift_in,
   output wire msb,
   output wire [W-1:0] data
);
   reg [W-1:0] data_q;
   assign msb = data_q[W-1];
   assign data = data_q;
   always @(posedge clk) begin
      if (rst) begin
         data_q <= {W{1'b0}};
      end else if (ce) begin
         if (load) begin
            data_q <= load_data;
         // [RQ12] msb first, shift left
         end else if (shift) begin
            data_q <= {data_q[W-2:0], shift_in};
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/twsm_ctrl.v ----
// two-wire single-master sequencer with bit-bang bypass
`timescale 1ns/100ps
`default_nettype none
`include "twsm_map.vh"
// Contract
// [RQ1] sole master, no arbitration, any number of slaves
// [RQ2] all bit timing comes from the system clock
// [RQ3] fixed divide-by-16 prescale stage
// [RQ4] programmable divider slows bit rate to 100 kHz or less
// [RQ5] bit rate is clock / (4*(16*div+4))
// [RQ6] slave may hold clock low; master waits for release
// [RQ7] start: data falls while clock high
// [RQ8] start only at cycle begin or after a whole byte
// [RQ9] stop: data rises while clock high, allowed anytime
// [RQ10] data stable while clock high except start and stop
// [RQ11] write: start, two or three acked bytes, stop
// [RQ12] bytes from 24-bit register shifted left, msb first
// [RQ13] bit 0 of first byte: low write, high read
// [RQ14] control bit picks two or three byte write
// [RQ15] read: start, acked byte, receive byte, nack, stop
// [RQ16] received byte shifts into third byte field
// [RQ17] completion raises an interrupt
// [RQ18] status shows whether all acknowledges arrived
// [RQ19] software may disable sequencer and drive pins directly
// [RQ20] lines open-drain; actual levels sensed
// [RQ21] ninth clock samples ack; missing ack clears success
module twsm_ctrl #(
   parameter DIV_W = `TWSM_DIV_W
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire start,
   input wire [7:0] first_tx_byte,
   input wire [7:0] second_tx_byte,
   input wire [7:0] third_byte_or_rx_data,
   input wire three_byte_write_select,
   input wire [DIV_W-1:0] bit_rate_divider,
   input wire hw_enable,
   input wire sw_scl,
   input wire sw_sda,
   input wire scl_in,
   input wire sda_in,
   output wire scl_out,
   output wire scl_oe_n,
   output wire sda_out,
   output wire sda_oe_n,
   output wire [23:0] data_out,
   output wire busy,
   output reg done_irq,
   output reg slave_ack_ok_status,
   output wire scl_level,
   output wire sda_level
);
   // ==================================================
   // states
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_START = 6'h02;
   localparam [5:0] S_BIT = 6'h04;
   localparam [5:0] S_ACK = 6'h08;
   localparam [5:0] S_STOP = 6'h10;
   localparam [5:0] S_DONE = 6'h20;

   reg [5:0] state_q;
   reg [1:0] ph_q;
   reg [2:0] bit_q;
   reg [1:0] byte_q;
   reg [1:0] nbytes_q;
   reg rd_q;
   reg scl_q;
   reg sda_q;
   reg rx_q;
   wire tick;
   wire adv;
   wire hold;
   wire run;
   wire msb;
   wire sh_load;
   wire sh_shift;
   wire rx_byte;
   wire last_byte;
   wire scl_drv;
   wire sda_drv;

   assign run = hw_enable && (state_q != S_IDLE) && (state_q != S_DONE);
   assign busy = run;
   // [RQ2] phase ticks from the system clock
   twsm_tick #(.DIV_W(DIV_W)) u_tick (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .run(run && !hold),
      .bit_rate_divider(bit_rate_divider),
      .tick(tick)
   );

   // [RQ6] slave keeps scl low after release: phase restarts on release
   assign hold = scl_q && !scl_in;
   assign adv = tick && !hold;
   assign rx_byte = rd_q && (byte_q == 2'h1);
   assign last_byte = (byte_q == nbytes_q);
   assign sh_load = ce && start && (state_q == S_IDLE ||
      state_q == S_DONE) && hw_enable;
   // [RQ16] read data enters the low byte as the register shifts
   assign sh_shift = (state_q == S_BIT) && adv && (ph_q == 2'h3);

   twsm_shift #(.W(`TWSM_DATA_W)) u_shift (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .load(sh_load),
      .load_data({first_tx_byte, second_tx_byte, third_byte_or_rx_data}),
      .shift(sh_shift),
      .shift_in(rx_byte ? rx_q : 1'b0),
      .msb(msb),
      .data(data_out)
   );

   // ==================================================
   // sequencer
   // each bit is four phases: 0 scl low/set data, 1 scl high,
   // 2 scl high/sample, 3 scl low
   always @(posedge clk) begin
      if (rst) begin
         state_q <= S_IDLE;
         ph_q <= 2'h0;
         bit_q <= 3'h0;
         byte_q <= 2'h0;
         nbytes_q <= 2'h0;
         rd_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rx_q <= 1'b0;
         done_irq <= 1'b0;
         slave_ack_ok_status <= 1'b0;
      end else if (ce) begin
         done_irq <= 1'b0;
         case (state_q)
            S_IDLE, S_DONE: begin
               scl_q <= 1'b1;
               sda_q <= 1'b1;
               // [RQ8] start only from an idle bus
               if (start && hw_enable) begin
                  state_q <= S_START;
                  ph_q <= 2'h0;
                  bit_q <= 3'h0;
                  byte_q <= 2'h0;
                  // [RQ13] read when bit 0 of first byte is high
                  rd_q <= first_tx_byte[0];
                  // [RQ14] [RQ11] two or three bytes on write
                  nbytes_q <= first_tx_byte[0] ? 2'h1 :
                     (three_byte_write_select ? 2'h2 : 2'h1);
                  slave_ack_ok_status <= 1'b1;
               end
            end
            S_START: if (adv) begin
               ph_q <= ph_q + 2'h1;
               // [RQ7] data falls while scl high, then scl falls
               if (ph_q == 2'h1) sda_q <= 1'b0;
               if (ph_q == 2'h3) begin
                  scl_q <= 1'b0;
                  state_q <= S_BIT;
               end
            end
            S_BIT: if (adv) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  // [RQ10] data changes only while scl low
                  2'h0: sda_q <= rx_byte ? 1'b1 : msb;
                  2'h1: scl_q <= 1'b1;
                  2'h2: rx_q <= sda_in;
                  default: begin
                     scl_q <= 1'b0;
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == 3'h7) state_q <= S_ACK;
                  end
               endcase
            end
            S_ACK: if (adv) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  // [RQ15] master nack after the received byte
                  2'h0: sda_q <= 1'b1;
                  2'h1: scl_q <= 1'b1;
                  2'h2: begin
                     // [RQ21] ninth clock ack sample
                     if (!rx_byte && sda_in) slave_ack_ok_status <= 1'b0;
                  end
                  default: begin
                     scl_q <= 1'b0;
                     byte_q <= byte_q + 2'h1;
                     // [RQ9] stop after last byte or a missing ack
                     if (last_byte || (!rx_byte && sda_in)) begin
                        state_q <= S_STOP;
                     end else begin
                        state_q <= S_BIT;
                     end
                  end
               endcase
            end
            S_STOP: if (adv) begin
               ph_q <= ph_q + 2'h1;
               case (ph_q)
                  2'h0: sda_q <= 1'b0;
                  2'h1: scl_q <= 1'b1;
                  // [RQ9] data rises while scl high
                  2'h2: sda_q <= 1'b1;
                  default: begin
                     state_q <= S_DONE;
                     // [RQ17] [RQ18] completion pulse with status
                     done_irq <= 1'b1;
                  end
               endcase
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ==================================================
   // pins
   // [RQ19] bit-bang bypass when sequencer disabled
   assign scl_drv = hw_enable ? scl_q : sw_scl;
   assign sda_drv = hw_enable ? sda_q : sw_sda;
   // [RQ20] open drain: only ever drive low, release for high
   // [RQ1] no arbitration logic: lines are assumed ours alone
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_n = scl_drv;
   assign sda_oe_n = sda_drv;
   assign scl_level = scl_in;
   assign sda_level = sda_in;
endmodule
`default_nettype wire

// ---- verification/twsm_chk_assertions.sv ----
// port assertions for the two-wire sequencer
`timescale 1ns/100ps
`default_nettype none
module twsm_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic hw_enable,
   input wire logic sw_scl,
   input wire logic sw_sda,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic busy,
   input wire logic done_irq,
   input wire logic slave_ack_ok_status,
   input wire logic scl_level,
   input wire logic sda_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ====
   // bus conditions
   start_busy_a: assert property (
      hw_enable && scl_level && $fell(sda_level) |-> busy)
      else $error("start while idle");
   stop_done_a: assert property (
      hw_enable && busy && scl_level && $rose(sda_level)
      |-> ##[1:250] done_irq) else $error("rise without completion");
   done_pulse_a: assert property (
      done_irq |=> !done_irq) else $error("completion pulse too long");
   idle_release_a: assert property (
      hw_enable && $past(hw_enable) && !busy |-> scl_oe_n && sda_oe_n)
      else $error("line held while idle");
   pins_low_a: assert property (
      !scl_out && !sda_out) else $error("pin drives high");
   bypass_a: assert property (
      !hw_enable && !$past(hw_enable) && $stable(sw_scl) && $stable(sw_sda)
      |-> scl_oe_n == sw_scl && sda_oe_n == sw_sda)
      else $error("bypass not followed");
   status_set_a: assert property (
      hw_enable && $past(hw_enable) && $rose(busy)
      |-> ##[0:1] slave_ack_ok_status)
      else $error("status not set at start");
   stretch_wait_a: assert property (
      busy && scl_oe_n && !scl_level
      |=> !hw_enable || (scl_oe_n && $stable(sda_oe_n)))
      else $error("stretch ignored");
   cover property (done_irq && slave_ack_ok_status);
   cover property (done_irq && !slave_ack_ok_status);
   cover property (busy && scl_oe_n && !scl_level);
endmodule
bind twsm_ctrl twsm_chk chk_i (.*);
`default_nettype wire

// ---- verification/twsm_slave.sv ----
// behavioural slave on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module twsm_slave (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   input wire logic stretch,
   input wire logic [7:0] rd_byte,
   output logic scl_rel,
   output logic sda_rel,
   output logic [7:0] got
);
   int n = -1;
   int b = 0;
   logic rd = 1'h0;
   // bits gather apart from got so the clock of a stop cannot shift in
   logic [7:0] sh = 8'h00;
   initial begin
      scl_rel = 1'h1;
      sda_rel = 1'h1;
      got = 8'h00;
   end
   always @(negedge sda) if (scl) begin
      n = -1;
      b = 0;
      rd = 1'h0;
   end
   always @(posedge scl) if (n >= 0 && n < 8) sh = {sh[6:0], sda};
   // drive only while clock low, then stretch
   always @(negedge scl) begin
      n = n + 1;
      if (n == 8) got = sh;
      if (n == 9) begin
         n = 0;
         b = b + 1;
      end
      if (b == 1 && n == 0) rd = got[0];
      if (n == 8) sda_rel = rd | ~ack_en;
      else sda_rel = !(rd && b == 1) | rd_byte[7 - n];
      if (stretch) begin
         scl_rel = 1'h0;
         // outlast the master's release; let go off the sampling edge
         repeat (130) @(negedge clk);
         scl_rel = 1'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/two_wire_single_master_tb.sv ----
// testbench for the two-wire single-master sequencer
`timescale 1ns/100ps
`default_nettype none
module two_wire_single_master_tb;
   logic clk, rst, ce, start, sel, hw_en, sw_scl, sw_sda, ack_en, stretch;
   logic scl_oe_n, sda_oe_n, scl_rel, sda_rel, busy, done_irq, ok;
   logic [7:0] b0, b1, b2, rd_byte, got;
   logic [3:0] div;
   logic [23:0] data_out;
   wire scl = scl_oe_n & scl_rel;
   wire sda = sda_oe_n & sda_rel;
   int err_count = 0;
   int samples_checked = 0;
   int cyc;
   twsm_ctrl DUT (.clk(clk), .rst(rst), .ce(ce), .start(start),
      .first_tx_byte(b0), .second_tx_byte(b1), .third_byte_or_rx_data(b2),
      .three_byte_write_select(sel), .bit_rate_divider(div),
      .hw_enable(hw_en), .sw_scl(sw_scl), .sw_sda(sw_sda), .scl_in(scl),
      .sda_in(sda), .scl_out(), .scl_oe_n(scl_oe_n), .sda_out(),
      .sda_oe_n(sda_oe_n), .data_out(data_out), .busy(busy),
      .done_irq(done_irq), .slave_ack_ok_status(ok), .scl_level(),
      .sda_level());
   twsm_slave slave (.clk(clk), .scl(scl), .sda(sda), .ack_en(ack_en),
      .stretch(stretch), .rd_byte(rd_byte), .scl_rel(scl_rel),
      .sda_rel(sda_rel), .got(got));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task results;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ====
   // one transfer: second byte fixed, waits for completion
   task xfer(input logic [7:0] a, input logic [7:0] c, input logic w3);
      @(posedge clk);
      b0 <= a;
      b1 <= 8'h5A;
      b2 <= c;
      sel <= w3;
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      cyc = 1;
      while (done_irq !== 1'h1 && cyc < 9000) begin
         @(negedge clk);
         cyc++;
      end
      chk("done", 24'h1, done_irq);
   endtask
   task t_write3;
      xfer(8'hA0, 8'hC3, 1'h1);
      chk("last byte", 24'hC3, got);
      chk("ack ok", 24'h1, ok);
      // 116 phases of 16*1+4 clocks after the start edge
      chk("rate", 24'h1, cyc >= 2316 && cyc <= 2328);
   endtask
   task t_write2;
      xfer(8'h42, 8'h77, 1'h0);
      chk("last byte", 24'h5A, got);
   endtask
   task t_read;
      rd_byte <= 8'h96;
      xfer(8'hA1, 8'h00, 1'h1);
      chk("rx", 24'h96, data_out[7:0]);
      chk("ack ok", 24'h1, ok);
   endtask
   task t_nack;
      ack_en <= 1'h0;
      xfer(8'hA0, 8'h11, 1'h1);
      chk("ack ok", 24'h0, ok);
      ack_en <= 1'h1;
   endtask
   task t_stretch;
      @(posedge clk);
      stretch <= 1'h1;
      div <= 4'h2;
      xfer(8'hA0, 8'h3C, 1'h1);
      chk("last byte", 24'h3C, got);
      chk("ack ok", 24'h1, ok);
      // 116 phases of 36 clocks, each of 28 low clocks held 57 longer
      chk("slowed", 24'h1, cyc >= 5764 && cyc <= 5784);
      stretch <= 1'h0;
   endtask
   task t_freeze;
      @(posedge clk);
      ce <= 1'h0;
      start <= 1'h1;
      repeat (4) @(negedge clk);
      chk("frozen", 24'h0, busy);
      @(posedge clk);
      ce <= 1'h1;
      start <= 1'h0;
   endtask
   task t_bypass;
      @(posedge clk);
      hw_en <= 1'h0;
      sw_scl <= 1'h0;
      start <= 1'h1;
      repeat (3) @(negedge clk);
      chk("pins", 24'h1, {scl_oe_n, sda_oe_n});
      chk("busy", 24'h0, busy);
      @(posedge clk);
      sw_scl <= 1'h1;
      sw_sda <= 1'h0;
      repeat (3) @(negedge clk);
      chk("pins", 24'h2, {scl_oe_n, sda_oe_n});
      @(posedge clk);
      hw_en <= 1'h1;
      sw_sda <= 1'h1;
      start <= 1'h0;
   endtask
   initial begin
      {rst, hw_en, sw_scl, sw_sda, ack_en} = 5'h1F;
      {start, sel, stretch} = 3'h0;
      ce = 1'h1;
      {b0, b1, b2, rd_byte} = 32'h0;
      div = 4'h1;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      chk("reset", 24'h3, {scl_oe_n, sda_oe_n});
      t_write3;
      t_write2;
      t_read;
      t_nack;
      t_stretch;
      t_bypass;
      t_freeze;
      results;
   end
   initial begin
      #(20000 * 100);
      err_count++;
      results;
   end
endmodule
`default_nettype wire
